// >>> common/bmr_pkg.sv
// package of constants and types for the branch, move and return executer
package bmr_pkg;
    // ==========================================================
    // instruction word layout
    localparam int INSN_W = 14;
    localparam int PC_W = 10;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 6;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 4;
    localparam int FILE_DEPTH = 64;
    localparam int DEST_BIT = 6;
    // ==========================================================
    // opcode patterns (arbitrary encoding chosen for this core)
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_SUB_POP = 14'h0010;
    localparam logic [13:0] OP_IRQ_EXIT = 14'h0011;
    localparam logic [3:0] OP_JUMP_HI = 4'hA;
    localparam logic [5:0] OP_LIT_HI = 6'h14;
    localparam logic [5:0] OP_LITEXIT_HI = 6'h15;
    localparam logic [7:0] OP_W2F_HI = 8'h01;
    localparam logic [6:0] OP_FREAD_HI = 7'h04;
    // ==========================================================
    // reset values
    localparam logic [9:0] PC_RESET = 10'h000;
    localparam logic [7:0] WREG_RESET = 8'h00;
    // ==========================================================
    // execution states
    typedef enum logic [1:0] {BMR_EXEC, BMR_FLUSH} bmr_state_t;
    // ==========================================================
    // decoded instruction class
    typedef enum logic [3:0] {
        BMR_I_NOP, BMR_I_JUMP, BMR_I_LIT, BMR_I_W2F, BMR_I_FREAD,
        BMR_I_LITEXIT, BMR_I_IRQEXIT, BMR_I_SUBPOP, BMR_I_OTHER
    } bmr_insn_t;
endpackage : bmr_pkg

// >>> rtl/bmr_decode.sv
// combinational instruction class decoder
`timescale 1ns/1ps
module bmr_decode (
    // instruction word
    input wire logic [13:0] insn_in,
    // decoded class
    output bmr_pkg::bmr_insn_t kind_out
);
    // match fixed opcode fields, whole-word matches first
    wire is_nop = (insn_in == bmr_pkg::OP_NOP);
    wire is_sub = (insn_in == bmr_pkg::OP_SUB_POP);
    wire is_irq = (insn_in == bmr_pkg::OP_IRQ_EXIT);
    wire is_jump = (insn_in[13:10] == bmr_pkg::OP_JUMP_HI);
    wire is_lit = (insn_in[13:8] == bmr_pkg::OP_LIT_HI);
    wire is_lx = (insn_in[13:8] == bmr_pkg::OP_LITEXIT_HI);
    wire is_w2f = (insn_in[13:6] == bmr_pkg::OP_W2F_HI);
    wire is_fr = (insn_in[13:7] == bmr_pkg::OP_FREAD_HI);
    assign kind_out = is_nop ? bmr_pkg::BMR_I_NOP :
                      is_sub ? bmr_pkg::BMR_I_SUBPOP :
                      is_irq ? bmr_pkg::BMR_I_IRQEXIT :
                      is_jump ? bmr_pkg::BMR_I_JUMP :
                      is_lit ? bmr_pkg::BMR_I_LIT :
                      is_lx ? bmr_pkg::BMR_I_LITEXIT :
                      is_w2f ? bmr_pkg::BMR_I_W2F :
                      is_fr ? bmr_pkg::BMR_I_FREAD : bmr_pkg::BMR_I_OTHER;
endmodule : bmr_decode

// >>> rtl/bmr_exec.sv
// execution of jump, move, nop and return instructions of the core
`timescale 1ns/1ps
module bmr_exec (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // fetched instruction
    input wire logic [13:0] insn_in,
    input wire logic insn_valid_in,
    // core state seen outside
    output logic [9:0] pc_out,
    output logic [7:0] working_register_out,
    output logic zero_flag_out,
    output logic global_irq_allow_out,
    output logic [3:0] stack_level_out,
    output logic flush_out,
    output logic [7:0] file_probe_out,
    // file probe address
    input wire logic [5:0] probe_addr_in
);
    // ==========================================================
    // storage
    // program counter and working state
    logic [9:0] pc;
    logic [7:0] wreg;
    logic zflag;
    logic irq_allow;
    // return stack and its level
    logic [3:0] sp;
    logic [9:0] stack_mem [0:7];
    // file registers and their read-back port
    logic [7:0] file_mem [0:63];
    logic [7:0] probe;
    // discard marker for the slot after a two-cycle instruction
    logic flush;
    // decoded class of the word in the fetch slot
    bmr_pkg::bmr_insn_t kind;

    // ==========================================================
    // decode
    // the class is a pure function of the word in the fetch slot
    bmr_decode u_dec (
        .insn_in(insn_in),
        .kind_out(kind)
    );

    // ==========================================================
    // stack arithmetic
    // level after a pop; an empty stack stays empty instead of wrapping
    function automatic logic [3:0] level_after_pop(input logic [3:0] level);
        if (level == 4'h0) begin
            return 4'h0;
        end
        return level - 4'h1;
    endfunction : level_after_pop

    // ==========================================================
    // operand fields and next values
    // a slot presented while the marker is up is never executed
    wire run = insn_valid_in && !flush; // fetched slot discarded while flushing
    // operand fields of the word
    wire [9:0] jump_addr = insn_in[9:0];
    wire [7:0] literal = insn_in[7:0];
    wire [5:0] faddr = insn_in[5:0];
    wire dest_file = insn_in[bmr_pkg::DEST_BIT];
    // read before this edge's write, so a copy onto itself sees the old value
    wire [7:0] file_val = file_mem[faddr];
    // top of the return stack
    wire [3:0] sp_dec = level_after_pop(sp);
    wire [2:0] top_idx = sp_dec[2:0];
    wire [9:0] top_pc = stack_mem[top_idx];
    // the three returns share the pop path; jump and returns take two cycles
    wire is_pop = (kind == bmr_pkg::BMR_I_LITEXIT) || (kind == bmr_pkg::BMR_I_IRQEXIT) ||
                  (kind == bmr_pkg::BMR_I_SUBPOP);
    wire two_cycle = run && (is_pop || kind == bmr_pkg::BMR_I_JUMP);
    // sequential successor of the current pc
    wire [9:0] pc_inc = pc + 10'h001;
    // next values and file write port
    logic [9:0] next_pc;
    logic [7:0] next_wreg;
    logic next_zflag;
    logic next_irq;
    logic [3:0] next_sp;
    logic file_we;
    logic [7:0] file_wdata;

    // ==========================================================
    // per-instruction effects
    always_comb begin
        next_pc = pc;
        next_wreg = wreg;
        next_zflag = zflag;
        next_irq = irq_allow;
        next_sp = sp;
        file_we = 1'b0;
        file_wdata = wreg;
        // every presented slot moves the pc on unless a taken jump or return loads it, the discarded one included
        if (insn_valid_in) begin
            next_pc = pc_inc;
        end
        // effects belong only to a taken instruction
        if (run) begin
            case (kind)
                bmr_pkg::BMR_I_JUMP: begin
                    next_pc = jump_addr;
                end
                bmr_pkg::BMR_I_LIT: begin
                    next_wreg = literal;
                end
                bmr_pkg::BMR_I_W2F: begin
                    file_we = 1'b1;
                    file_wdata = wreg;
                end
                bmr_pkg::BMR_I_FREAD: begin
                    if (dest_file) begin
                        file_we = 1'b1;
                        file_wdata = file_val;
                    end else begin
                        next_wreg = file_val;
                    end
                    next_zflag = (file_val == 8'h00);
                end
                bmr_pkg::BMR_I_LITEXIT: begin
                    next_wreg = literal;
                    next_pc = top_pc;
                    next_sp = sp_dec;
                    next_irq = 1'b1;
                end
                bmr_pkg::BMR_I_IRQEXIT: begin
                    next_pc = top_pc;
                    next_sp = sp_dec;
                    next_irq = 1'b1;
                end
                bmr_pkg::BMR_I_SUBPOP: begin
                    next_pc = top_pc;
                    next_sp = sp_dec;
                end
                default: begin
                    next_pc = pc_inc;
                end
            endcase
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pc <= bmr_pkg::PC_RESET;
            wreg <= bmr_pkg::WREG_RESET;
            zflag <= 1'b0;
            irq_allow <= 1'b0;
            sp <= 4'h0;
        end else begin
            pc <= next_pc;
            wreg <= next_wreg;
            zflag <= next_zflag;
            irq_allow <= next_irq;
            sp <= next_sp;
        end
    end

    // discard marker, up for exactly the slot after a jump or return
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flush <= 1'b0;
        end else begin
            flush <= two_cycle; // second cycle drops the fetched word
        end
    end

    // ==========================================================
    // return stack
    // nothing pushes here, so entries keep their reset value and a pop
    // from an empty stack lands on a known address instead of an unknown
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < bmr_pkg::STACK_DEPTH; i++) begin
                stack_mem[i] <= bmr_pkg::PC_RESET;
            end
        end else begin
            for (int i = 0; i < bmr_pkg::STACK_DEPTH; i++) begin
                stack_mem[i] <= stack_mem[i];
            end
        end
    end

    // ==========================================================
    // file registers
    // array write, no reset needed
    always_ff @(posedge clock_in) begin
        if (file_we) begin
            file_mem[faddr] <= file_wdata;
        end
    end

    // registered read-back port, one cycle behind its address
    always_ff @(posedge clock_in) begin
        probe <= file_mem[probe_addr_in];
    end

    // ==========================================================
    // outputs, each straight from its register
    // program state
    assign pc_out = pc;
    assign working_register_out = wreg;
    assign zero_flag_out = zflag;
    assign global_irq_allow_out = irq_allow;
    // stack and discard status
    assign stack_level_out = sp;
    assign flush_out = flush;
    // file read-back
    assign file_probe_out = probe;
endmodule : bmr_exec

// >>> testbench/bmr_exec_properties.sv
// checker of the executer's port behaviour
`timescale 1ns/1ps
module bmr_chk (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // instruction side
    input wire logic [13:0] insn_in,
    input wire logic insn_valid_in,
    input wire logic [5:0] probe_addr_in,
    // core state
    input wire logic [9:0] pc_out,
    input wire logic [7:0] working_register_out,
    input wire logic zero_flag_out,
    input wire logic global_irq_allow_out,
    input wire logic [3:0] stack_level_out,
    input wire logic flush_out,
    input wire logic [7:0] file_probe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ==========================================================
    // an instruction is taken only outside the discarded slot
    wire logic tk = insn_valid_in && !flush_out;
    property p_jmp; tk && insn_in[13:10] == 4'hA |=> pc_out == $past(insn_in[9:0]) && flush_out; endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong");
    property p_dsc; flush_out |=> !flush_out && $stable(working_register_out) && $stable(zero_flag_out); endproperty
    a_dsc: assert property (p_dsc) else $error("discarded slot acted");
    property p_lit; tk && insn_in[13:8] == 6'h14 |=> working_register_out == $past(insn_in[7:0])
        && $stable(zero_flag_out) && !flush_out; endproperty
    a_lit: assert property (p_lit) else $error("literal load wrong");
    property p_w2f; tk && insn_in[13:6] == 8'h01 |=> $stable(working_register_out)
        && $stable(zero_flag_out); endproperty
    a_w2f: assert property (p_w2f) else $error("copy to file changed state");
    property p_frd; tk && insn_in[13:7] == 7'h04 && probe_addr_in == insn_in[5:0] |=> zero_flag_out ==
        (file_probe_out == 8'h00) && ($past(insn_in[6]) || working_register_out == file_probe_out); endproperty
    a_frd: assert property (p_frd) else $error("file read wrong");
    property p_lx; tk && insn_in[13:8] == 6'h15 |=> global_irq_allow_out && flush_out
        && working_register_out == $past(insn_in[7:0]); endproperty
    a_lx: assert property (p_lx) else $error("literal exit wrong");
    property p_ix; tk && insn_in == 14'h0011 |=> global_irq_allow_out && flush_out
        && stack_level_out == 4'h0; endproperty
    a_ix: assert property (p_ix) else $error("interrupt exit wrong");
    property p_sp; tk && insn_in == 14'h0010 |=> $stable(global_irq_allow_out) && flush_out; endproperty
    a_sp: assert property (p_sp) else $error("subroutine pop wrong");
    property p_nop; tk && insn_in == 14'h0000 |=> pc_out == $past(pc_out) + 10'h001 && !flush_out; endproperty
    a_nop: assert property (p_nop) else $error("nop wrong");
    // main scenarios reached
    c_jmp: cover property (tk && insn_in[13:10] == 4'hA);
    c_frd: cover property (tk && insn_in[13:7] == 7'h04);
    c_ix: cover property (tk && insn_in == 14'h0011);
endmodule : bmr_chk
bind bmr_exec bmr_chk bmr_chk_inst (.clock_in(clock_in), .rst_in(rst_in), .insn_in(insn_in),
    .insn_valid_in(insn_valid_in), .probe_addr_in(probe_addr_in), .pc_out(pc_out),
    .working_register_out(working_register_out), .zero_flag_out(zero_flag_out),
    .global_irq_allow_out(global_irq_allow_out), .stack_level_out(stack_level_out),
    .flush_out(flush_out), .file_probe_out(file_probe_out));

// >>> testbench/testbench.sv
// self-checking bench of the executer
`timescale 1ns/1ps
module testbench;
    logic clock_in = 0;
    logic rst_in = 1;
    logic [13:0] insn_in = 14'h0000;
    logic insn_valid_in = 0;
    logic [5:0] probe_addr_in = 6'h00;
    logic [9:0] pc_out;
    logic [7:0] working_register_out, file_probe_out;
    logic zero_flag_out, global_irq_allow_out, flush_out;
    logic [3:0] stack_level_out;
    int fails = 0, n_checks = 0, cyc = 0;
    always #12.5 clock_in = ~clock_in;
    bmr_exec bmr_exec_inst (.clock_in(clock_in), .rst_in(rst_in), .insn_in(insn_in),
        .insn_valid_in(insn_valid_in), .pc_out(pc_out), .working_register_out(working_register_out),
        .zero_flag_out(zero_flag_out), .global_irq_allow_out(global_irq_allow_out),
        .stack_level_out(stack_level_out), .flush_out(flush_out), .file_probe_out(file_probe_out),
        .probe_addr_in(probe_addr_in));
    // ==========================================================
    // present one slot; the probe follows the file address
    task go(input logic [13:0] i, input logic v = 1'b1);
        @(posedge clock_in);
        insn_in <= i;
        probe_addr_in <= i[5:0];
        insn_valid_in <= v;
    endtask : go
    task settle;
        go(14'h0000, 1'b0);
        #1;
    endtask : settle
    task chk(input string n, input logic [9:0] e, input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task rst;
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
    endtask : rst
    task wrap_up;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // moves between working register and files
    task t_move;
        go(14'h0000); go(14'h1400); go(14'h0046); go(14'h1455); go(14'h0045); go(14'h0246); settle;
        chk("wreg", 10'h055, working_register_out);
        chk("zero", 10'h001, zero_flag_out);
        go(14'h1411); go(14'h0205); settle;
        chk("wreg", 10'h055, working_register_out);
        chk("zero", 10'h000, zero_flag_out);
        chk("file", 10'h055, file_probe_out);
        chk("pc", 10'h008, pc_out);
        $display("move test done");
    endtask : t_move
    // jump with a successor that must be dropped
    task t_jump;
        go(14'h2923); go(14'h1499); #1;
        chk("pc", 10'h123, pc_out);
        chk("flush", 10'h001, flush_out);
        settle;
        chk("pc", 10'h124, pc_out);
        chk("wreg", 10'h055, working_register_out);
        chk("zero", 10'h000, zero_flag_out);
        $display("jump test done");
    endtask : t_jump
    // the three returns
    task t_ret;
        rst; go(14'h0010); settle;
        chk("pc", bmr_pkg::PC_RESET, pc_out);
        chk("irq", 10'h000, global_irq_allow_out);
        chk("flush", 10'h001, flush_out);
        go(14'h15AB); settle;
        chk("wreg", 10'h0AB, working_register_out);
        chk("irq", 10'h001, global_irq_allow_out);
        go(14'h0010); settle;
        chk("irq", 10'h001, global_irq_allow_out);
        rst; go(14'h0011); settle;
        chk("irq", 10'h001, global_irq_allow_out);
        chk("level", 10'h000, stack_level_out);
        $display("return test done");
    endtask : t_ret
    // cut a hang short
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 500) begin
            fails++;
            wrap_up;
        end
    end
    initial begin
        rst;
        t_move;
        t_jump;
        t_ret;
        settle;
        wrap_up;
    end
endmodule : testbench
